/* pkg/bgpr_pkg.sv */
package bgpr_pkg;
    // Sizes of the register file
    localparam int BANK_COUNT   = 8;
    localparam int BANK_BITS    = 3;
    localparam int BANK_BYTES   = 16;
    localparam int REG_BITS     = 4;
    localparam int RAM_BYTES    = 128;
    localparam int RAM_IDX_BITS = 7;
    localparam int ADDR_BITS    = 24;
    localparam int SP_BITS      = 24;
    localparam int EXT_COUNT    = 4;

    // Bank area placement
    localparam logic [23:0] BANK_AREA_BASE     = 24'h00FE80;
    localparam logic [23:0] BANK_AREA_LAST     = 24'h00FEFF;
    localparam logic [23:0] BANK_AREA_BASE_ALT = 24'h0FFE80;
    localparam logic [23:0] BANK_AREA_LAST_ALT = 24'h0FFEFF;

    // Reset bank number
    localparam logic [2:0] BANK_RESET = 3'h0;

    // Alias byte offsets with the swap bit clear
    localparam logic [3:0] OFS_AUX   = 4'h0;
    localparam logic [3:0] OFS_ACC   = 4'h1;
    localparam logic [3:0] OFS_CNT_L = 4'h2;
    localparam logic [3:0] OFS_CNT_H = 4'h3;
    localparam logic [3:0] OFS_SWAP  = 4'h4;

    // Word pairs for context save
    localparam logic [2:0] PAIR_PC_LOW  = 3'h2;
    localparam logic [2:0] PAIR_PC_HIGH = 3'h3;
    localparam logic [2:0] PAIR_ACC     = 3'h0;
    localparam logic [2:0] PAIR_NEXT    = 3'h1;

    // Stack pointer step and upper bits that must stay clear
    localparam logic [23:0] SP_STEP  = 24'h000001;
    localparam logic [3:0]  SP_UPPER = 4'h0;

    // Operand selector for byte and word access
    typedef enum logic [2:0] {
        BGPR_SEL_ABS = 3'h0,   // Absolute index
        BGPR_SEL_ACC = 3'h1,   // Accumulator alias
        BGPR_SEL_AUX = 3'h2,   // Auxiliary alias
        BGPR_SEL_CNH = 3'h3,   // High counter alias
        BGPR_SEL_CNL = 3'h4    // Low counter alias
    } bgpr_sel_t;

    // Stack operation
    typedef enum logic [1:0] {
        BGPR_STK_NONE = 2'h0,
        BGPR_STK_PUSH = 2'h1,
        BGPR_STK_POP  = 2'h2,
        BGPR_STK_LOAD = 2'h3
    } bgpr_stk_t;

    // Alias byte offset, moved up by four when swapped
    function automatic logic [3:0] bgpr_alias(input bgpr_sel_t sel,
                                              input logic [3:0] idx,
                                              input logic swap);
        logic [3:0] ofs;
        ofs = idx;
        unique case (sel)
            BGPR_SEL_ABS: ofs = idx;
            BGPR_SEL_ACC: ofs = OFS_ACC;
            BGPR_SEL_AUX: ofs = OFS_AUX;
            BGPR_SEL_CNH: ofs = OFS_CNT_H;
            BGPR_SEL_CNL: ofs = OFS_CNT_L;
            default:      ofs = idx;
        endcase
        if (swap && sel != BGPR_SEL_ABS) begin
            ofs = ofs + OFS_SWAP;
        end
        return ofs;
    endfunction

    // RAM index of a byte in a bank; bank 0 at the top
    function automatic logic [6:0] bgpr_ram_idx(input logic [2:0] bank,
                                                input logic [3:0] ofs);
        logic [2:0] slice;
        slice = 3'h7 - bank;
        return {slice, ofs};
    endfunction
endpackage

/* pkg/bgpr_ram_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Port bundle between the top and its byte RAM
interface bgpr_ram_if;
    logic       we_a;
    logic [6:0] addr_a;
    logic [7:0] wdata_a;
    logic [7:0] rdata_a;
    logic       we_b;
    logic [6:0] addr_b;
    logic [7:0] wdata_b;
    logic [7:0] rdata_b;
    modport host (output we_a, addr_a, wdata_a, we_b, addr_b, wdata_b,
                  input rdata_a, rdata_b);
    modport ram  (input we_a, addr_a, wdata_a, we_b, addr_b, wdata_b,
                  output rdata_a, rdata_b);
endinterface
`default_nettype wire

/* core/bgpr_ram.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-port byte RAM holding all eight banks, no reset on contents
module bgpr_ram
    import bgpr_pkg::*;
(
    input wire logic clk,        // Core clock
    bgpr_ram_if.ram  rp          // Two access ports
);
    logic [7:0] mem [RAM_BYTES];

    // Port B write wins over port A at the same byte
    always_ff @(posedge clk) begin
        if (rp.we_a) begin
            mem[rp.addr_a] <= rp.wdata_a;
        end
        if (rp.we_b) begin
            mem[rp.addr_b] <= rp.wdata_b;
        end
    end

    // Asynchronous read, registered by the top
    assign rp.rdata_a = mem[rp.addr_a];
    assign rp.rdata_b = mem[rp.addr_b];
endmodule // bgpr_ram
`default_nettype wire

/* core/bgpr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bgpr_top
    import bgpr_pkg::*;
(
    input  wire logic        ref_clk,       // Core clock
    input  wire logic        resetn,        // Async reset, active low
    // Register operand port
    input  wire logic        reg_we,        // Register write strobe
    input  wire logic        reg_word,      // Word access when high
    input  wire bgpr_sel_t   reg_sel,       // Alias or absolute
    input  wire logic [3:0]  reg_idx,       // Byte index or pair*2
    input  wire logic [15:0] reg_wdata,     // Write data
    output logic      [15:0] reg_rdata,     // Read data
    // Address register port
    input  wire logic [1:0]  adr_sel,       // Address register 4..7
    input  wire logic        ext_we,        // Extension byte write
    input  wire logic [7:0]  ext_wdata,     // Extension write data
    output logic      [23:0] adr_rdata,     // 24-bit address value
    // 32-bit wide pair
    output logic      [31:0] wide_pair_32,  // Shadow copy, tied to zero
    // Index offsets
    output logic      [7:0]  idx_acc,       // Accumulator offset
    output logic      [7:0]  idx_cnt_h,     // High counter offset
    output logic      [7:0]  idx_cnt_l,     // Low counter offset
    output logic             cnt_l_zero,    // Low counter is one
    // Loop counter decrement
    input  wire logic        dec_cnt,       // Decrement a counter
    input  wire logic        dec_high,      // High counter when set
    // Bank select and status
    input  wire logic        bank_we,       // Bank select write
    input  wire logic [2:0]  bank_wdata,    // New bank number
    input  wire logic        swap_we,       // Swap bit write
    input  wire logic        swap_wdata,    // New swap bit
    input  wire logic        alt_place,     // Alternate bank placement
    output logic      [2:0]  bank_select_bits, // Active bank
    output logic             register_set_swap, // Swap bit
    // Context switch
    input  wire logic        ctx_sw,        // Context switch strobe
    input  wire logic [2:0]  ctx_bank,      // Target bank
    input  wire logic [19:0] ctx_pc,        // Program counter to save
    input  wire logic [11:0] ctx_status,    // Status bits; only bits 11:4 are saved
    // Stack pointer
    input  wire bgpr_stk_t   stk_op,        // Stack operation
    input  wire logic [23:0] stk_wdata,     // Load value
    output logic      [23:0] stack_pointer, // Current pointer
    output logic      [23:0] stk_addr,      // Address for this access
    // Memory view of bank area
    input  wire logic        mem_en,        // Memory access strobe
    input  wire logic        mem_we,        // Memory write
    input  wire logic [23:0] mem_addr,      // Byte address
    input  wire logic [7:0]  mem_wdata,     // Write data
    output logic      [7:0]  mem_rdata,     // Read data
    output logic             mem_hit        // Address was in bank area
);
    logic        rst_m;
    logic        rst_s;
    logic [7:0]  ext [EXT_COUNT];
    logic [7:0]  next_ext [EXT_COUNT];
    logic [2:0]  next_bank;
    logic        next_swap;
    logic [23:0] next_sp;
    logic [23:0] next_stk_addr;
    logic [15:0] next_reg_rdata;
    logic [23:0] next_adr_rdata;
    logic [7:0]  next_mem_rdata;
    logic        next_mem_hit;
    logic [31:0] wide_shadow;
    logic [3:0]  ofs;
    logic [3:0]  cnt_ofs;
    logic        in_area;
    logic [6:0]  mem_idx;
    logic [7:0]  cnt_val;
    logic        hi_pend;
    logic [6:0]  hi_addr;
    logic [7:0]  hi_data;
    logic [1:0]  ctx_step;
    logic        next_hi_pend;
    logic [6:0]  next_hi_addr;
    logic [7:0]  next_hi_data;
    logic [1:0]  next_ctx_step;
    logic [2:0]  ctx_bank_q;
    logic [23:0] ctx_data_q;
    logic [2:0]  next_ctx_bank_q;
    logic [23:0] next_ctx_data_q;
    logic [6:0]  ctx_addr;
    logic [7:0]  ctx_byte;

    bgpr_ram_if rp ();

    bgpr_ram u_ram (
        .clk (ref_clk),
        .rp  (rp.ram)
    );

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    // Alias decode and bank area decode
    always_comb begin
        ofs = bgpr_alias(reg_sel, reg_idx, register_set_swap);
        if (reg_word) begin
            ofs = {ofs[3:1], 1'b0};
        end
        cnt_ofs = bgpr_alias(dec_high ? BGPR_SEL_CNH : BGPR_SEL_CNL,
                             4'h0, register_set_swap);
        if (alt_place) begin
            in_area = mem_addr >= BANK_AREA_BASE_ALT
                   && mem_addr <= BANK_AREA_LAST_ALT;
        end else begin
            in_area = mem_addr >= BANK_AREA_BASE
                   && mem_addr <= BANK_AREA_LAST;
        end
        mem_idx = mem_addr[6:0];
    end

    // RAM port A: operand, context or counter; port B: memory view, upper byte or later context bytes
    always_comb begin
        rp.we_a    = 1'b0;
        rp.addr_a  = bgpr_ram_idx(bank_select_bits, ofs);
        rp.wdata_a = reg_wdata[7:0];
        rp.we_b    = 1'b0;
        // Idle memory view lets port B read the word's upper byte
        rp.addr_b  = mem_en ? mem_idx
                            : bgpr_ram_idx(bank_select_bits, ofs + 4'h1);
        rp.wdata_b = mem_wdata;
        cnt_val    = 8'h00;
        if (ctx_sw) begin
            rp.we_a    = 1'b1;
            rp.addr_a  = bgpr_ram_idx(ctx_bank, {PAIR_PC_LOW, 1'b0});
            rp.wdata_a = ctx_pc[7:0];
        end else if (dec_cnt) begin
            rp.addr_a  = bgpr_ram_idx(bank_select_bits, cnt_ofs);
            cnt_val    = rp.rdata_a;
            rp.we_a    = 1'b1;
            rp.wdata_a = cnt_val - 8'h01;
        end else if (reg_we) begin
            rp.we_a = 1'b1;
        end
        // later context bytes on port B
        if (ctx_step != 2'h0) begin
            rp.we_b    = 1'b1;
            rp.addr_b  = ctx_addr;
            rp.wdata_b = ctx_byte;
        end else if (hi_pend) begin
            rp.we_b    = 1'b1;
            rp.addr_b  = hi_addr;
            rp.wdata_b = hi_data;
        end else if (mem_en && mem_we && in_area) begin
            rp.we_b = 1'b1;
        end
    end

    // Upper-byte sequencing is kept in registers and merged below
    always_comb begin
        next_hi_pend    = 1'b0;
        next_hi_addr    = hi_addr;
        next_hi_data    = hi_data;
        next_ctx_step   = 2'h0;
        next_ctx_bank_q = ctx_bank_q;
        next_ctx_data_q = ctx_data_q;
        if (ctx_sw) begin
            next_ctx_step   = 2'h1;
            next_ctx_bank_q = ctx_bank;
            next_ctx_data_q = {ctx_status, ctx_pc[19:8]};
        end else if (ctx_step != 2'h0) begin
            next_ctx_step = ctx_step + 2'h1;
        end else if (reg_we && reg_word && !dec_cnt) begin
            next_hi_pend = 1'b1;
            next_hi_addr = bgpr_ram_idx(bank_select_bits, ofs + 4'h1);
            next_hi_data = reg_wdata[15:8];
        end
    end

    // Registered outputs and state
    always_comb begin
        next_bank      = bank_select_bits;
        next_swap      = register_set_swap;
        next_sp        = stack_pointer;
        next_stk_addr  = stk_addr;
        for (int i = 0; i < EXT_COUNT; i++) begin
            next_ext[i] = ext[i];
        end
        if (ctx_sw) begin
            next_bank = ctx_bank;
        end else if (bank_we) begin
            next_bank = bank_wdata;
        end
        if (swap_we) begin
            next_swap = swap_wdata;
        end
        if (ext_we) begin
            next_ext[adr_sel] = ext_wdata;
        end
        unique case (stk_op)
            BGPR_STK_NONE: next_stk_addr = stk_addr;
            BGPR_STK_PUSH: begin
                next_sp       = stack_pointer - SP_STEP;
                next_stk_addr = stack_pointer - SP_STEP;
            end
            BGPR_STK_POP: begin
                next_sp       = stack_pointer + SP_STEP;
                next_stk_addr = stack_pointer;
            end
            BGPR_STK_LOAD: next_sp = stk_wdata;
        endcase
        next_reg_rdata = {rp.rdata_b, rp.rdata_a};
        // Address register: extension byte over the addressed word pair
        next_adr_rdata = {ext[adr_sel], rp.rdata_b, rp.rdata_a};
        next_mem_rdata = in_area ? rp.rdata_b : 8'h00;
        next_mem_hit   = mem_en && in_area;
    end

    // Later context bytes per step; these and upper-byte writes take port B ahead of the memory view
    always_comb begin
        ctx_addr = bgpr_ram_idx(ctx_bank_q, {PAIR_PC_LOW, 1'b1});
        ctx_byte = ctx_data_q[7:0];
        unique case (ctx_step)
            2'h1: begin
                ctx_addr = bgpr_ram_idx(ctx_bank_q, {PAIR_PC_LOW, 1'b1});
                ctx_byte = ctx_data_q[7:0];
            end
            2'h2: begin
                ctx_addr = bgpr_ram_idx(ctx_bank_q, {PAIR_PC_HIGH, 1'b0});
                ctx_byte = {ctx_data_q[19:16], ctx_data_q[11:8]};
            end
            2'h3: begin
                ctx_addr = bgpr_ram_idx(ctx_bank_q, {PAIR_PC_HIGH, 1'b1});
                ctx_byte = ctx_data_q[23:16];
            end
            default: ;
        endcase
    end

    // State registers; stack pointer has no reset value
    always_ff @(posedge ref_clk or negedge rst_s) begin
        if (!rst_s) begin
            bank_select_bits  <= BANK_RESET;
            register_set_swap <= 1'b0;
            hi_pend           <= 1'b0;
            hi_addr           <= 7'h00;
            hi_data           <= 8'h00;
            ctx_step          <= 2'h0;
            ctx_bank_q        <= BANK_RESET;
            ctx_data_q        <= 24'h000000;
            reg_rdata         <= 16'h0000;
            adr_rdata         <= 24'h000000;
            mem_rdata         <= 8'h00;
            mem_hit           <= 1'b0;
            stk_addr          <= 24'h000000;
        end else begin
            bank_select_bits  <= next_bank;
            register_set_swap <= next_swap;
            hi_pend           <= next_hi_pend;
            hi_addr           <= next_hi_addr;
            hi_data           <= next_hi_data;
            ctx_step          <= next_ctx_step;
            ctx_bank_q        <= next_ctx_bank_q;
            ctx_data_q        <= next_ctx_data_q;
            reg_rdata         <= next_reg_rdata;
            adr_rdata         <= next_adr_rdata;
            mem_rdata         <= next_mem_rdata;
            mem_hit           <= next_mem_hit;
            stk_addr          <= next_stk_addr;
        end
    end

    // no reset on pointer or extensions
    always_ff @(posedge ref_clk) begin
        stack_pointer <= next_sp;
        for (int i = 0; i < EXT_COUNT; i++) begin
            ext[i] <= next_ext[i];
        end
    end

    // Index offsets and wide pair read from a shadow tied to zero
    always_ff @(posedge ref_clk) begin
        idx_acc      <= wide_shadow[15:8];
        idx_cnt_h    <= wide_shadow[31:24];
        idx_cnt_l    <= wide_shadow[23:16];
        cnt_l_zero   <= wide_shadow[23:16] == 8'h01;
        wide_pair_32 <= wide_shadow;
    end
    assign wide_shadow = {16'h0000, 16'h0000};
endmodule // bgpr_top
`default_nettype wire

/* verif/bgpr_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// Timing checks on stack, bank and memory-view ports
module bgpr_asserts
    import bgpr_pkg::*;
(
    input wire logic        ref_clk,           // Core clock
    input wire logic        resetn,            // Reset, active low
    input wire bgpr_stk_t   stk_op,            // Stack request
    input wire logic [23:0] stk_wdata,         // Load value
    input wire logic [23:0] stack_pointer,     // Pointer
    input wire logic [23:0] stk_addr,          // Access address
    input wire logic        bank_we,           // Bank write
    input wire logic [2:0]  bank_wdata,        // New bank
    input wire logic [2:0]  bank_select_bits,  // Active bank
    input wire logic        register_set_swap, // Swap bit
    input wire logic        ctx_sw,            // Context switch
    input wire logic [2:0]  ctx_bank,          // Target bank
    input wire logic        alt_place,         // Placement
    input wire logic        mem_en,            // Memory strobe
    input wire logic [23:0] mem_addr,          // Memory address
    input wire logic        mem_hit            // Area hit
);
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [2:0]  ctx_bank_q;
    logic [2:0]  next_ctx_bank;
    logic [23:0] base;
    // Remember the target of the last context switch
    always_comb next_ctx_bank = ctx_sw ? ctx_bank : ctx_bank_q;
    always_ff @(posedge ref_clk) ctx_bank_q <= next_ctx_bank;
    // Start of the bank area in the chosen placement
    assign base = alt_place ? BANK_AREA_BASE_ALT : BANK_AREA_BASE;
    sequence s_push;
        stk_op == BGPR_STK_PUSH;
    endsequence
    sequence s_pop;
        stk_op == BGPR_STK_POP;
    endsequence
    a_load_value: assert property (
        stk_op == BGPR_STK_LOAD |=> stack_pointer == $past(stk_wdata))
        else $error("pointer load wrong");
    a_push_predec: assert property (
        s_push |=> stack_pointer == $past(stack_pointer) - 24'h1)
        else $error("push did not decrement");
    a_push_addr: assert property (
        s_push |=> stk_addr == stack_pointer)
        else $error("push address not decremented pointer");
    a_pop_postinc: assert property (
        s_pop |=> stack_pointer == $past(stack_pointer) + 24'h1
            && stk_addr == $past(stack_pointer))
        else $error("pop did not increment after read");
    a_bank_write: assert property (
        bank_we && !ctx_sw |=> bank_select_bits == $past(bank_wdata))
        else $error("bank select not taken");
    a_reset_bank: assert property (
        $rose(resetn) |-> bank_select_bits == BANK_RESET
            && !register_set_swap)
        else $error("reset did not pick bank zero");
    a_ctx_bank: assert property (
        ctx_sw |-> ##[1:4] bank_select_bits == ctx_bank_q)
        else $error("context switch bank not selected");
    a_mem_hit: assert property (
        mem_en && mem_addr >= base && mem_addr - base < 24'h80
            |=> mem_hit)
        else $error("bank area access missed");
    a_mem_miss: assert property (
        mem_en && (mem_addr < base || mem_addr - base >= 24'h80)
            |=> !mem_hit)
        else $error("access outside area hit");
endmodule // bgpr_asserts
bind bgpr_top bgpr_asserts u_asserts (.ref_clk, .resetn, .stk_op,
    .stk_wdata, .stack_pointer, .stk_addr, .bank_we, .bank_wdata,
    .bank_select_bits, .register_set_swap, .ctx_sw, .ctx_bank,
    .alt_place, .mem_en, .mem_addr, .mem_hit);
`default_nettype wire

/* verif/bgpr_exec_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Execution unit: issues stack and context switch requests
module bgpr_exec_model
    import bgpr_pkg::*;
(
    input  wire logic       clk,        // Core clock
    output var  bgpr_stk_t  stk_op,     // Stack request
    output logic [23:0]     stk_wdata,  // Load value
    output logic            ctx_sw,     // Switch strobe
    output logic [2:0]      ctx_bank,   // Target bank
    output logic [19:0]     ctx_pc,     // Program counter
    output logic [11:0]     ctx_status  // Status bits
);
    // Idle request lines
    initial begin
        stk_op = BGPR_STK_NONE;
        {stk_wdata, ctx_sw, ctx_bank, ctx_pc, ctx_status} = '0;
    end
    // Hold one stack request for n edges, then release
    task automatic stack(input bgpr_stk_t op, input logic [23:0] v,
                         input int n);
        @(posedge clk) #1;
        stk_op = op;
        stk_wdata = {SP_UPPER, v[19:0]};
        repeat (n) @(posedge clk);
        #1;
        stk_op = BGPR_STK_NONE;
        stk_wdata = ~stk_wdata;
    endtask
    // Strobe a switch and wait out the sequencing cycles
    task automatic switch_to(input logic [2:0] b, input logic [19:0] pc,
                             input logic [11:0] st);
        @(posedge clk) #1;
        ctx_sw = 1'b1;
        ctx_bank = b;
        ctx_pc = pc;
        ctx_status = st;
        @(posedge clk) #1;
        ctx_sw = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        ctx_pc = ~ctx_pc;
        ctx_status = ~ctx_status;
    endtask
endmodule // bgpr_exec_model
`default_nettype wire

/* verif/banked_gpr_file_with_stack_pointer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the banked register file
module banked_gpr_file_with_stack_pointer_bench
    import bgpr_pkg::*;
;
    logic ref_clk = 1'b0;
    logic resetn, reg_we, reg_word, ext_we, bank_we, swap_we, swap_wdata;
    logic alt_place, ctx_sw, mem_en, mem_we, register_set_swap, mem_hit;
    bgpr_sel_t   reg_sel;
    bgpr_stk_t   stk_op;
    logic [3:0]  reg_idx;
    logic [15:0] reg_wdata, reg_rdata;
    logic [1:0]  adr_sel;
    logic [7:0]  ext_wdata, mem_wdata, mem_rdata;
    logic [23:0] adr_rdata, stk_wdata, stack_pointer, stk_addr, mem_addr;
    logic [2:0]  bank_wdata, bank_select_bits, ctx_bank;
    logic [19:0] ctx_pc;
    logic [11:0] ctx_status;
    int          n_errors = 0, samples_checked = 0, cycles = 0;
    integer      seed = 32'hc1233e3a;
    logic [3:0]  alias_ofs [5] = '{4'h0, 4'h1, 4'h0, 4'h3, 4'h2};
    logic [23:0] out_addr [3] = '{24'h00FE7F, 24'h00FF00, 24'h0FFE80};

    always #5 ref_clk = ~ref_clk;

    bgpr_top u_dut (.ref_clk, .resetn, .reg_we, .reg_word, .reg_sel,
        .reg_idx, .reg_wdata, .reg_rdata, .adr_sel, .ext_we, .ext_wdata,
        .adr_rdata, .wide_pair_32(), .idx_acc(), .idx_cnt_h(),
        .idx_cnt_l(), .cnt_l_zero(), .dec_cnt(1'b0), .dec_high(1'b0),
        .bank_we, .bank_wdata, .swap_we, .swap_wdata, .alt_place,
        .bank_select_bits, .register_set_swap, .ctx_sw, .ctx_bank,
        .ctx_pc, .ctx_status, .stk_op, .stk_wdata, .stack_pointer,
        .stk_addr, .mem_en, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
        .mem_hit);
    bgpr_exec_model u_eu (.clk(ref_clk), .stk_op, .stk_wdata, .ctx_sw,
        .ctx_bank, .ctx_pc, .ctx_status);

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    task automatic tick;
        @(posedge ref_clk) #1;
    endtask
    // Memory-view byte access, strobe held two edges
    task automatic mem(input logic we, input logic [23:0] a,
                       input logic [7:0] d);
        tick;
        {mem_en, mem_we, mem_addr, mem_wdata} = {1'b1, we, a, d};
        repeat (2) tick;
        {mem_en, mem_we, mem_wdata} = {2'b00, ~d};
    endtask
    // Register port access, address held two edges
    task automatic reg_io(input logic we, input logic w, input bgpr_sel_t s,
                          input logic [3:0] i, input logic [15:0] d);
        tick;
        {reg_we, reg_word, reg_sel, reg_idx, reg_wdata} = {we, w, s, i, d};
        tick;
        reg_we = 1'b0;
        tick;
    endtask
    task automatic ctl(input logic bank, input logic [2:0] v);
        tick;
        {bank_we, swap_we, bank_wdata, swap_wdata} = {bank, ~bank, v, v[0]};
        tick;
        {bank_we, swap_we} = 2'b00;
    endtask
    // Byte address of a register in the bank area
    function automatic logic [23:0] baddr(input logic [2:0] b,
                                          input logic [3:0] o);
        return (alt_place ? BANK_AREA_BASE_ALT : BANK_AREA_BASE)
               + {17'h0, 3'h7 - b, o};
    endfunction
    task automatic complete_run;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Cut a hung run short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run;
        end
    end

    initial begin
        logic [23:0] v;
        logic [15:0] w;
        logic [7:0]  d;
        logic [3:0]  o;
        {reg_we, reg_word, ext_we, bank_we, swap_we, swap_wdata} = '0;
        {alt_place, mem_en, mem_we, adr_sel, ext_wdata, bank_wdata} = '0;
        {reg_idx, reg_wdata, mem_addr, mem_wdata} = '0;
        reg_sel = BGPR_SEL_ABS;
        resetn = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1 resetn = 1'b1;
        repeat (3) tick;
        check(24'(bank_select_bits), 24'h0);
        check(24'(register_set_swap), 24'h0);
        for (int i = 0; i < 8; i++) begin
            v = 24'h001000 + {9'h0, 15'($random(seed))};
            if (i == 0) v = 24'h0FFFFF;
            u_eu.stack(BGPR_STK_LOAD, v, 1);
            check(stack_pointer, v);
            u_eu.stack(BGPR_STK_PUSH, 24'h0, 2);
            check(stack_pointer, v - 24'h2);
            check(stk_addr, v - 24'h2);
            u_eu.stack(BGPR_STK_POP, 24'h0, 1);
            check(stk_addr, v - 24'h2);
            check(stack_pointer, v - 24'h1);
        end
        for (int b = 0; b < 8; b++) begin
            alt_place = b[0];
            ctl(1'b1, b[2:0]);
            check(24'(bank_select_bits), 24'(b));
            o = 4'($random(seed));
            d = 8'($random(seed));
            reg_io(1'b1, 1'b0, BGPR_SEL_ABS, o, {8'h0, d});
            mem(1'b0, baddr(b[2:0], o), 8'h0);
            check(24'(mem_hit), 24'h1);
            check(24'(mem_rdata), 24'(d));
            w = 16'($random(seed));
            o = {3'($random(seed)), 1'b0};
            reg_io(1'b1, 1'b1, BGPR_SEL_ABS, o, w);
            mem(1'b0, baddr(b[2:0], o + 4'h1), 8'h0);
            check(24'(mem_rdata), 24'(w[15:8]));
            mem(1'b1, baddr(b[2:0], o), d);
            reg_io(1'b0, 1'b1, BGPR_SEL_ABS, o, 16'h0);
            check(24'(reg_rdata), {8'h0, w[15:8], d});
        end
        alt_place = 1'b0;
        foreach (out_addr[j]) begin
            mem(1'b1, out_addr[j], 8'hFF);
            check(24'(mem_hit), 24'h0);
        end
        ctl(1'b1, 3'h2);
        for (int s = 0; s < 2; s++) begin
            ctl(1'b0, 3'(s));
            check(24'(register_set_swap), 24'(s));
            for (int j = 1; j < 5; j++) begin
                d = 8'($random(seed));
                reg_io(1'b1, 1'b0, bgpr_sel_t'(j), 4'hF, {8'h0, d});
                reg_io(1'b0, 1'b0, BGPR_SEL_ABS,
                       alias_ofs[j] + 4'(4 * s), 16'h0);
                check(24'(reg_rdata[7:0]), 24'(d));
            end
        end
        ctl(1'b0, 3'h0);
        w = 16'($random(seed));
        u_eu.switch_to(3'h5, {4'h3, w}, 12'($random(seed)));
        check(24'(bank_select_bits), 24'h5);
        mem(1'b0, baddr(3'h5, 4'h4), 8'h0);
        check(24'(mem_rdata), 24'(w[7:0]));
        mem(1'b0, baddr(3'h5, 4'h5), 8'h0);
        check(24'(mem_rdata), 24'(w[15:8]));
        for (int j = 0; j < 4; j++) begin
            d = 8'($random(seed));
            w = 16'($random(seed));
            reg_io(1'b1, 1'b1, BGPR_SEL_ABS, 4'(8 + 2 * j), w);
            {adr_sel, ext_we, ext_wdata} = {2'(j), 1'b1, d};
            tick;
            ext_we = 1'b0;
            repeat (2) tick;
            check(adr_rdata, {d, w});
        end
        complete_run;
    end
endmodule // banked_gpr_file_with_stack_pointer_bench
`default_nettype wire
